// ### core/nvm_byte_store.sv
// byte-wide nonvolatile data store with its address, data and control registers
// assumes the cpu end issues no access while stall is high
`timescale 1ns/10ps

// What this block does
// - 512 separately readable and writable bytes
// - registers sit in cpu i/o space
// - read strobe stalls cpu four cycles
// - write strobe stalls cpu two cycles
// - cpu waits write strobe zero first
// - no write start while self-programming busy
// - address and data loads optional, any order
// - arm, then strobe within four cycles
// - expired arm window means no write
// - cpu keeps interrupts off during sequence
// - write lasts 27072 rc oscillator cycles
// - hardware clears write strobe when done
// - busy write blocks reads and address changes
// - read: poll, load address, strobe, take data
// - nine-bit address, upper bits read zero
// - arm self-clears after four; unarmed strobe ignored
// - ready interrupt level while strobe clear
// - read data ready right after strobe
module nvm_byte_store
    import nvm_pkg::*;
#(
    parameter int BYTES = MEM_BYTES,
    parameter int OSC_CYCLES = WRITE_OSC_CYCLES,
    parameter int DIV = RC_DIV
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus from the cpu
    nvm_io_if.device io,
    // user side status
    output logic write_busy
);
    localparam int OSC_W = $clog2(OSC_CYCLES + 1);

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic [ADDR_W-1:0] wr_addr;
        logic [7:0] wr_data;
        logic busy;
        logic arm;
        logic [2:0] arm_cnt;
        logic rie;
        logic [2:0] stall_cnt;
        logic stall;
        logic irq;
        logic [7:0] rdata;
        logic [OSC_W-1:0] osc_cnt;
    } dev_state_type;

    dev_state_type s_q;
    dev_state_type s_d;
    logic [7:0] mem [BYTES];
    logic [7:0] rd_byte;
    logic osc_tick;
    logic commit;

    // register read view
    function automatic logic [7:0] reg_read(input logic [IO_ADDR_W-1:0] a, input dev_state_type s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            IO_ADDR_LO: v = s.addr[7:0];
            IO_ADDR_HI: v = {7'h00, s.addr[8]};
            IO_DATA: v = s.data;
            IO_CTRL: begin
                v[CTRL_RIE] = s.rie;
                v[CTRL_ARM] = s.arm;
                v[CTRL_WRITE] = s.busy;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // write timing base
    rc_tick_gen #(
        .DIV(DIV)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(s_q.busy),
        .tick(osc_tick)
    );

    assign rd_byte = mem[s_q.addr];
    assign commit = s_q.busy && osc_tick && (s_q.osc_cnt == OSC_W'(1));

    always_comb begin
        s_d = s_q;

        if (s_q.stall_cnt != 3'h0) begin
            s_d.stall_cnt = s_q.stall_cnt - 3'h1;
        end

        // arm window times out on its own
        if (s_q.arm_cnt != 3'h0) begin
            s_d.arm_cnt = s_q.arm_cnt - 3'h1;
            if (s_q.arm_cnt == 3'h1) begin
                s_d.arm = 1'b0;
            end
        end

        if (s_q.busy && osc_tick) begin
            s_d.osc_cnt = s_q.osc_cnt - 1'b1;
            if (commit) begin
                s_d.busy = 1'b0;
            end
        end

        if (io.io_rd) begin
            s_d.rdata = reg_read(io.io_addr, s_q);
        end

        if (io.io_wr) begin
            case (io.io_addr)
                IO_ADDR_LO: begin
                    if (!s_q.busy) begin
                        s_d.addr[7:0] = io.io_wdata;
                    end
                end
                IO_ADDR_HI: begin
                    if (!s_q.busy) begin
                        s_d.addr[8] = io.io_wdata[0];
                    end
                end
                IO_DATA: begin
                    s_d.data = io.io_wdata;
                end
                IO_CTRL: begin
                    s_d.rie = io.io_wdata[CTRL_RIE];
                    if (io.io_wdata[CTRL_ARM] && !io.io_wdata[CTRL_WRITE]) begin
                        s_d.arm = 1'b1;
                        s_d.arm_cnt = ARM_CYCLES;
                    end
                    // an unarmed strobe, or one during flash programming, does nothing
                    if (io.io_wdata[CTRL_WRITE] && s_q.arm && !s_q.busy && !io.self_program_busy) begin
                        s_d.wr_addr = s_q.addr;
                        s_d.wr_data = s_q.data;
                        s_d.busy = 1'b1;
                        s_d.osc_cnt = OSC_W'(OSC_CYCLES);
                        s_d.stall_cnt = WRITE_STALL;
                    end else if (io.io_wdata[CTRL_READ] && !s_q.busy) begin
                        s_d.data = rd_byte;
                        s_d.stall_cnt = READ_STALL;
                    end
                end
                default: begin
                end
            endcase
        end

        s_d.stall = (s_d.stall_cnt != 3'h0);
        s_d.irq = s_d.rie && io.global_int_en && !s_d.busy;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // array keeps its contents through reset
    always_ff @(posedge aclk) begin
        if (commit) begin
            mem[s_q.wr_addr] <= s_q.wr_data;
        end
    end

    assign io.io_rdata = s_q.rdata;
    assign io.stall = s_q.stall;
    assign io.ready_irq = s_q.irq;
    assign write_busy = s_q.busy;
endmodule

// ### core/nvm_cpu_port.sv
// cpu end: runs register accesses and the timed nvm sequences on command from axi4-lite
// assumes the byte store on the other side of nvm_io_if and the same clock
`timescale 1ns/10ps
module nvm_cpu_port
    import nvm_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [AXI_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // interrupt
    output logic irq,
    // register bus to the byte store
    nvm_io_if.cpu io
);
    typedef enum logic [1:0] {H_IDLE, H_GAP, H_WAIT} host_fsm_type;
    typedef struct packed {
        host_fsm_type state;
        op_type op;
        logic [5:0] cmd_addr;
        logic [7:0] cmd_data;
        logic [1:0] step;
        logic io_wr;
        logic io_rd;
        logic [5:0] io_addr;
        logic [7:0] io_wdata;
        logic [7:0] result;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic gie;
        logic spm;
        logic gie_out;
        logic ready_prev;
        logic irq;
        logic aw_have;
        logic w_have;
        logic [AXI_AW-1:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } host_state_type;

    host_state_type s_q;
    host_state_type s_d;

    // one access of a sequence: {is read, address, data}; step 2 is always the last
    function automatic logic [14:0] step_access(input host_state_type s, input logic [1:0] st);
        logic [7:0] rie;
        rie = {4'h0, s.cmd_data[CTRL_RIE], 3'h0};
        if (st == 2'h0) begin
            return {1'b1, IO_CTRL, 8'h00};
        end
        unique case (s.op)
            OP_IO_WRITE: return {1'b0, s.cmd_addr, s.cmd_data};
            OP_IO_READ: return {1'b1, s.cmd_addr, 8'h00};
            OP_NVM_WRITE: return (st == 2'h1) ? {1'b0, IO_CTRL, rie | 8'h04} : {1'b0, IO_CTRL, rie | 8'h02};
            OP_NVM_READ: return (st == 2'h1) ? {1'b0, IO_CTRL, rie | 8'h01} : {1'b1, IO_DATA, 8'h00};
        endcase
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    logic [14:0] acc;
    logic [31:0] wv;

    always_comb begin
        s_d = s_q;
        s_d.io_wr = 1'b0;
        s_d.io_rd = 1'b0;
        acc = step_access(s_q, s_q.step);
        wv = 32'h0;

        unique case (s_q.state)
            H_IDLE: begin
            end
            H_GAP: s_d.state = H_WAIT;
            H_WAIT: begin
                if (!io.stall) begin
                    if (acc[14]) begin
                        s_d.result = io.io_rdata;
                    end
                    if (s_q.step == 2'h0 && (io.io_rdata[CTRL_WRITE] || s_q.spm)) begin
                        s_d.step = 2'h0;
                    end else if (s_q.step == 2'h2) begin
                        s_d.state = H_IDLE;
                    end else begin
                        s_d.step = s_q.step + 2'h1;
                    end
                    if (s_q.step != 2'h2 || !(s_q.step == 2'h2)) begin
                        s_d.state = (s_q.step == 2'h2) ? H_IDLE : H_GAP;
                    end
                    if (s_q.step == 2'h2) begin
                        s_d.irq_stat[IRQ_DONE] = 1'b1;
                    end
                end
            end
        endcase

        // axi write
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            wv = s_q.w_data & strb_mask(s_q.w_strb);
            case (s_q.aw_addr)
                REG_CMD: begin
                    if (s_q.state == H_IDLE) begin
                        s_d.cmd_data = wv[CMD_DATA_LSB +: 8];
                        s_d.cmd_addr = wv[CMD_ADDR_LSB +: 6];
                        s_d.op = op_type'(wv[CMD_OP_LSB +: 2]);
                        s_d.step = (wv[CMD_OP_LSB + 1]) ? 2'h0 : 2'h2;
                        s_d.state = H_GAP;
                    end
                end
                REG_IRQ_STAT: s_d.irq_stat = s_d.irq_stat & ~wv[1:0];
                REG_IRQ_MASK: s_d.irq_mask = wv[1:0];
                REG_CTRL: begin
                    s_d.gie = wv[HC_GIE];
                    s_d.spm = wv[HC_SPM];
                end
                REG_RESULT, REG_STATUS: begin
                end
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end

        // events set after the clear so that set wins
        if (s_q.state == H_WAIT && !io.stall && s_q.step == 2'h2) begin
            s_d.irq_stat[IRQ_DONE] = 1'b1;
        end
        if (io.ready_irq && !s_q.ready_prev) begin
            s_d.irq_stat[IRQ_READY] = 1'b1;
        end
        s_d.ready_prev = io.ready_irq;

        // issue the access of the current step
        if (s_d.state == H_GAP && (s_q.state != H_GAP)) begin
            acc = step_access(s_d, s_d.step);
            s_d.io_wr = !acc[14];
            s_d.io_rd = acc[14];
            s_d.io_addr = acc[13:8];
            s_d.io_wdata = acc[7:0];
        end

        // axi read
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = 32'h0;
            case (araddr)
                REG_CMD: s_d.rdata = {14'h0, s_q.op, 2'h0, s_q.cmd_addr, s_q.cmd_data};
                REG_RESULT: s_d.rdata = {24'h0, s_q.result};
                REG_STATUS: s_d.rdata = {30'h0, io.ready_irq, s_q.state != H_IDLE};
                REG_IRQ_STAT: s_d.rdata = {30'h0, s_q.irq_stat};
                REG_IRQ_MASK: s_d.rdata = {30'h0, s_q.irq_mask};
                REG_CTRL: s_d.rdata = {30'h0, s_q.spm, s_q.gie};
                default: s_d.rresp = RESP_SLVERR;
            endcase
        end

        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
        s_d.gie_out = s_d.gie && (s_d.state == H_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;
    assign irq = s_q.irq;
    assign io.io_wr = s_q.io_wr;
    assign io.io_rd = s_q.io_rd;
    assign io.io_addr = s_q.io_addr;
    assign io.io_wdata = s_q.io_wdata;
    assign io.global_int_en = s_q.gie_out;
    assign io.self_program_busy = s_q.spm;
endmodule

// ### core/nvm_io_if.sv
// i/o register bus between the cpu port and the byte store
// assumes both ends on aclk; all signals driven from flip-flops
`timescale 1ns/10ps
interface nvm_io_if;
    import nvm_pkg::*;
    logic [IO_ADDR_W-1:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic stall;
    logic ready_irq;
    logic global_int_en;
    logic self_program_busy;
    modport device(
        input io_addr, io_wr, io_rd, io_wdata, global_int_en, self_program_busy,
        output io_rdata, stall, ready_irq
    );
    modport cpu(
        output io_addr, io_wr, io_rd, io_wdata, global_int_en, self_program_busy,
        input io_rdata, stall, ready_irq
    );
endinterface

// ### core/nvm_pkg.sv
// constants shared by the byte store, its cpu port and the interface between them
// assumes a single 20 MHz clock for both ends
package nvm_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int MEM_BYTES = 512;
    localparam int ADDR_W = 9;
    localparam int WRITE_OSC_CYCLES = 27072;
    localparam int WRITE_TIME_US = 3300;
    localparam int RC_PERIOD_NS = WRITE_TIME_US * 1000 / WRITE_OSC_CYCLES;
    localparam int RC_DIV = (RC_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : RC_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [2:0] ARM_CYCLES = 3'h4;
    localparam logic [2:0] READ_STALL = 3'h4;
    localparam logic [2:0] WRITE_STALL = 3'h2;
    // i/o register locations
    localparam int IO_ADDR_W = 6;
    localparam logic [5:0] IO_CTRL = 6'h1f;
    localparam logic [5:0] IO_DATA = 6'h20;
    localparam logic [5:0] IO_ADDR_LO = 6'h21;
    localparam logic [5:0] IO_ADDR_HI = 6'h22;
    // control register bits
    localparam int CTRL_READ = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_ARM = 2;
    localparam int CTRL_RIE = 3;
    // axi register map of the cpu port
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_RESULT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam logic [7:0] REG_CTRL = 8'h14;
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_OP_LSB = 16;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_READY = 1;
    localparam int HC_GIE = 0;
    localparam int HC_SPM = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_READY = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {OP_IO_WRITE, OP_IO_READ, OP_NVM_WRITE, OP_NVM_READ} op_type;
endpackage

// ### core/rc_tick_gen.sv
// enable pulse standing in for the calibrated rc oscillator
// assumes run comes from a flip-flop on aclk
`timescale 1ns/10ps
module rc_tick_gen
    import nvm_pkg::*;
#(
    parameter int DIV = RC_DIV
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } tick_state_type;
    tick_state_type s_q;
    tick_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == CW'(DIV - 1)) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// ### test/nvm_io_sva.sv
// assertions on the i/o register link between the cpu port and the byte store
// assumes one clock, synchronous active-low reset, and both ends on the link
`timescale 1ns/10ps
module nvm_io_sva
    import nvm_pkg::*;
#(
    parameter int OSC_CYCLES = WRITE_OSC_CYCLES,
    parameter int DIV = RC_DIV
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    input wire logic [IO_ADDR_W-1:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic stall,
    input wire logic ready_irq,
    input wire logic global_int_en,
    input wire logic self_program_busy,
    // store status
    input wire logic write_busy
);
    // one more cycle than the tick count: the rc tick is registered
    localparam int WRITE_CYCLES = OSC_CYCLES * DIV + 1;
    logic [2:0] arm_q;
    logic [15:0] busy_q;
    logic ctl_wr;
    logic strobe;
    logic ok_strobe;
    assign ctl_wr = io_wr && io_addr == IO_CTRL;
    assign strobe = ctl_wr && io_wdata[CTRL_WRITE];
    assign ok_strobe = strobe && arm_q != 3'h0 && !write_busy && !self_program_busy;
    // arm window: strobe counts on the four edges after the arming edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arm_q <= 3'h0;
            busy_q <= 16'h0;
        end else begin
            if (ctl_wr && io_wdata[CTRL_ARM] && !io_wdata[CTRL_WRITE]) begin
                arm_q <= ARM_CYCLES;
            end else if (arm_q != 3'h0) begin
                arm_q <= arm_q - 3'h1;
            end
            busy_q <= write_busy ? busy_q + 16'h1 : 16'h0;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_stall_four: assert property (ctl_wr && io_wdata[CTRL_READ] && !write_busy |=> stall [*4] ##1 !stall)
        else $error("read strobe stall not four cycles");
    a_write_stall_two: assert property (ok_strobe |=> stall [*2] ##1 !stall)
        else $error("write strobe stall not two cycles");
    a_write_starts: assert property (ok_strobe |=> write_busy)
        else $error("armed strobe did not start a write");
    a_unarmed_ignored: assert property (strobe && arm_q == 3'h0 && !write_busy |=> !write_busy && !stall)
        else $error("unarmed strobe had an effect");
    a_spm_blocks_write: assert property (strobe && self_program_busy && !write_busy |=> !write_busy)
        else $error("write started while self-programming");
    a_write_time: assert property ($fell(write_busy) |-> busy_q == WRITE_CYCLES)
        else $error("write time wrong");
    a_busy_blocks_read: assert property (ctl_wr && io_wdata[CTRL_READ] && write_busy |=> !stall)
        else $error("read performed during write");
    a_ready_irq_quiet: assert property ((write_busy || !global_int_en) [*2] |-> !ready_irq)
        else $error("ready interrupt while busy or disabled");
    a_addr_hi_zero: assert property (io_rd && io_addr == IO_ADDR_HI |=> io_rdata[7:1] == 7'h0)
        else $error("upper address bits not zero");
    c_write: cover property (ok_strobe);
    c_write_done: cover property ($fell(write_busy));
    c_read: cover property (ctl_wr && io_wdata[CTRL_READ] && !write_busy);
endmodule

// ### test/tb_top.sv
// testbench: axi4-lite master on the cpu port, byte store across the link
// assumes a 20 MHz clock and a shortened write time
`timescale 1ns/10ps
module tb_top;
    import nvm_pkg::*;
    localparam int OSC = 200;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, write_busy;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v;
    int fail_count = 0;
    int checks_done = 0;
    logic [8:0] tab_a [3] = '{9'h000, 9'h1ff, 9'h100};
    logic [7:0] tab_d [3] = '{8'ha5, 8'h3c, 8'h5a};

    always #25 aclk = ~aclk;

    nvm_io_if link();
    nvm_byte_store #(.OSC_CYCLES(OSC), .DIV(1)) i_nvm_byte_store(.aclk(aclk), .aresetn(aresetn), .io(link.device),
        .write_busy(write_busy));
    nvm_cpu_port i_nvm_cpu_port(.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq), .io(link.cpu));
    nvm_io_sva #(.OSC_CYCLES(OSC), .DIV(1)) i_nvm_io_sva(.aclk(aclk), .aresetn(aresetn), .io_addr(link.io_addr),
        .io_wr(link.io_wr), .io_rd(link.io_rd), .io_wdata(link.io_wdata), .io_rdata(link.io_rdata),
        .stall(link.stall), .ready_irq(link.ready_irq), .global_int_en(link.global_int_en),
        .self_program_busy(link.self_program_busy), .write_busy(write_busy));

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: response %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        axi_read(a);
        check_word(v, exp, what);
        check_resp(r, RESP_OKAY);
    endtask
    task automatic cmd(input op_type op, input logic [5:0] ia, input logic [7:0] d);
        axi_write(REG_CMD, (32'(op) << CMD_OP_LSB) | (32'(ia) << CMD_ADDR_LSB) | 32'(d));
        do axi_read(REG_STATUS); while (v[ST_BUSY] !== 1'b0);
    endtask
    task automatic iow(input logic [5:0] ia, input logic [7:0] d);
        cmd(OP_IO_WRITE, ia, d);
    endtask
    task automatic ior_chk(input logic [5:0] ia, input logic [7:0] exp, input string what);
        cmd(OP_IO_READ, ia, 8'h00);
        reg_chk(REG_RESULT, 32'(exp), what);
    endtask
    task automatic wait_idle;
        do begin
            cmd(OP_IO_READ, IO_CTRL, 8'h00);
            axi_read(REG_RESULT);
        end while (v[CTRL_WRITE] !== 1'b0);
    endtask
    task automatic nvm_write(input logic [8:0] a, input logic [7:0] d);
        wait_idle();
        iow(IO_ADDR_LO, a[7:0]);
        iow(IO_ADDR_HI, {7'h0, a[8]});
        iow(IO_DATA, d);
        cmd(OP_NVM_WRITE, 6'h00, 8'h00);
    endtask
    task automatic nvm_read_chk(input logic [8:0] a, input logic [7:0] exp);
        wait_idle();
        iow(IO_ADDR_LO, a[7:0]);
        iow(IO_ADDR_HI, {7'h0, a[8]});
        cmd(OP_NVM_READ, 6'h00, 8'h00);
        reg_chk(REG_RESULT, 32'(exp), "stored byte");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge aclk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_chk(REG_STATUS, 32'h0, "status after reset");
        reg_chk(REG_IRQ_STAT, 32'h0, "irq status after reset");
        axi_read(8'h18);
        check_word(v, 32'h0, "unmapped read");
        check_resp(r, RESP_SLVERR);
        axi_write(8'h18, 32'hffffffff);
        check_resp(r, RESP_SLVERR);
        ior_chk(IO_CTRL, 8'h00, "control after reset");
        $display("test reset done");
        for (int i = 0; i < 3; i++) nvm_write(tab_a[i], tab_d[i]);
        axi_read(REG_IRQ_STAT);
        check_word(32'(v[IRQ_DONE]), 32'h1, "done flag");
        for (int i = 0; i < 3; i++) nvm_read_chk(tab_a[i], tab_d[i]);
        iow(IO_ADDR_HI, 8'hff);
        ior_chk(IO_ADDR_HI, 8'h01, "address high");
        $display("test byte access done");
        wait_idle();
        iow(IO_DATA, 8'hc3);
        iow(IO_ADDR_LO, 8'h40);
        iow(IO_ADDR_HI, 8'h00);
        cmd(OP_NVM_WRITE, 6'h00, 8'h00);
        wait_idle();
        iow(IO_ADDR_LO, 8'h41);
        cmd(OP_NVM_WRITE, 6'h00, 8'h00);
        nvm_read_chk(9'h040, 8'hc3);
        nvm_read_chk(9'h041, 8'hc3);
        $display("test load order done");
        nvm_write(9'h007, 8'h11);
        ior_chk(IO_CTRL, 8'h02, "strobe held");
        iow(IO_ADDR_LO, 8'h09);
        iow(IO_CTRL, 8'h01);
        ior_chk(IO_ADDR_LO, 8'h07, "address during write");
        wait_idle();
        nvm_read_chk(9'h007, 8'h11);
        $display("test busy write done");
        iow(IO_CTRL, 8'h04);
        iow(IO_CTRL, 8'h02);
        ior_chk(IO_CTRL, 8'h00, "expired arm");
        nvm_read_chk(9'h007, 8'h11);
        $display("test arm window done");
        axi_write(REG_CTRL, 32'h2);
        iow(IO_CTRL, 8'h04);
        iow(IO_CTRL, 8'h02);
        iow(IO_DATA, 8'h99);
        axi_write(REG_CMD, 32'(OP_NVM_WRITE) << CMD_OP_LSB);
        repeat (50) @(posedge aclk);
        reg_chk(REG_STATUS, 32'h1, "held by self-programming");
        axi_write(REG_CTRL, 32'h0);
        do axi_read(REG_STATUS); while (v[ST_BUSY] !== 1'b0);
        nvm_read_chk(9'h007, 8'h99);
        $display("test self-program done");
        axi_write(REG_IRQ_STAT, 32'h3);
        axi_write(REG_CTRL, 32'h1);
        iow(IO_CTRL, 8'h08);
        reg_chk(REG_STATUS, 32'h2, "ready level");
        axi_read(REG_IRQ_STAT);
        check_word(32'(v[IRQ_READY]), 32'h1, "ready event");
        axi_write(REG_IRQ_MASK, 32'h0);
        reg_chk(REG_IRQ_MASK, 32'h0, "mask");
        check_word(32'(irq), 32'h0, "masked irq");
        axi_write(REG_IRQ_MASK, 32'h2);
        reg_chk(REG_IRQ_MASK, 32'h2, "mask");
        check_word(32'(irq), 32'h1, "unmasked irq");
        axi_write(REG_IRQ_STAT, 32'h3);
        reg_chk(REG_IRQ_STAT, 32'h0, "cleared status");
        check_word(32'(irq), 32'h0, "cleared irq");
        iow(IO_CTRL, 8'h00);
        reg_chk(REG_STATUS, 32'h0, "ready off");
        $display("test interrupt done");
        report_and_stop();
    end
endmodule
